//--- hw/iol_exec.sv
/*
 * iol_exec: executes the plain increment, increment-and-skip and
 * or-literal instructions against a private file and working register.
 * assumes: instr/instr_valid come from program memory logic on mclk,
 * one word per instruction cycle, already fetched one ahead.
 */
// Notes on behaviour
// - plain increment adds one, sets zero, one cycle
// - destination bit 0 to accumulator, 1 to file
// - skip-increment adds one, status left unchanged
// - zero result discards prefetched word, two cycles
// - or-literal into accumulator, zero updated, one cycle
`timescale 1ns/1ps
module iol_exec #(
    parameter int unsigned DATA_W  = 8,
    parameter int unsigned FADDR_W = 5
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic [11:0]         instr,
    input  wire logic                instr_valid,
    input  wire logic [4:0]          peek_addr,
    output logic      [7:0]          accum,
    output logic      [7:0]          status,
    output logic      [7:0]          peek_data,
    output logic                     skip_active,
    output logic                     exec_done
);

    // the encodings fix the widths; other values cannot be served
    if (DATA_W != iol_pkg::DATA_W || FADDR_W != iol_pkg::FADDR_W) begin : g_chk
        $error("iol_exec: DATA_W must be 8 and FADDR_W must be 5");
    end

    logic [7:0]        file_mem [iol_pkg::FILE_DEPTH];
    logic [7:0]        next_file_mem [iol_pkg::FILE_DEPTH];
    logic [7:0]        next_accum;
    logic [7:0]        next_status;
    logic [7:0]        next_peek_data;
    logic              next_skip_active;
    logic              next_exec_done;

    logic [4:0]        faddr;
    logic [7:0]        lit;
    logic [7:0]        src_val;
    logic              do_exec;
    iol_pkg::iol_op_t  op;
    logic [7:0]        result;
    logic              result_zero;
    logic              to_file;
    logic              upd_zero;

    assign faddr   = instr[iol_pkg::FADDR_LSB +: 5];
    assign lit     = instr[iol_pkg::LIT_LSB +: 8];
    assign src_val = file_mem[faddr];
    // a word arriving while a skip is pending is the discarded one
    assign do_exec = instr_valid && !skip_active;

    iol_alu u_alu (
        .instr       (instr),
        .accum       (accum),
        .file_val    (src_val),
        .op          (op),
        .result      (result),
        .result_zero (result_zero),
        .to_file     (to_file),
        .upd_zero    (upd_zero)
    );

    always_comb begin
        next_file_mem    = file_mem;
        next_accum       = accum;
        next_status      = status;
        next_skip_active = 1'b0;
        next_exec_done   = 1'b0;
        if (do_exec && op != iol_pkg::IOL_OP_NONE) begin
            next_exec_done = 1'b1;
            if (to_file) begin
                next_file_mem[faddr] = result;
            end else begin
                next_accum = result;
            end
            if (upd_zero) begin
                // only the zero bit moves; the rest of status is kept
                next_status[iol_pkg::ZERO_BIT] = result_zero;
            end
            // one-cycle flag: the discarded slot can never start another skip
            if (op == iol_pkg::IOL_OP_INC_SKIP && result_zero) begin
                next_skip_active = 1'b1;
            end
        end
        next_peek_data = next_file_mem[peek_addr];
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < iol_pkg::FILE_DEPTH; i++) begin
                file_mem[i] <= iol_pkg::FILE_RST;
            end
            accum       <= iol_pkg::ACCUM_RST;
            status      <= iol_pkg::STATUS_RST;
            peek_data   <= iol_pkg::FILE_RST;
            skip_active <= 1'b0;
            exec_done   <= 1'b0;
        end else begin
            file_mem    <= next_file_mem;
            accum       <= next_accum;
            status      <= next_status;
            peek_data   <= next_peek_data;
            skip_active <= next_skip_active;
            exec_done   <= next_exec_done;
        end
    end

    // checks
    // expectations rebuilt from operands, not from the alu's own result

    logic ex_inc;
    logic ex_inc_skip;
    logic ex_or_lit;
    assign ex_inc      = do_exec && op == iol_pkg::IOL_OP_INC_FILE;
    assign ex_inc_skip = do_exec && op == iol_pkg::IOL_OP_INC_SKIP;
    assign ex_or_lit   = do_exec && op == iol_pkg::IOL_OP_OR_LIT;

    property p_inc_to_accum;
        @(posedge mclk) disable iff (sys_rst)
        ex_inc && !instr[iol_pkg::DEST_BIT] |=> accum == $past(src_val) + 8'h01
            && status[iol_pkg::ZERO_BIT] == ($past(src_val) == 8'hff) && exec_done;
    endproperty
    a_inc_to_accum: assert property (p_inc_to_accum)
        else $error("increment to accumulator gave wrong value or flag");

    property p_inc_no_skip;
        @(posedge mclk) disable iff (sys_rst)
        ex_inc |=> !skip_active && exec_done;
    endproperty
    a_inc_no_skip: assert property (p_inc_no_skip)
        else $error("plain increment skipped or missed its cycle");

    property p_ignored_word;
        @(posedge mclk) disable iff (sys_rst)
        do_exec && op == iol_pkg::IOL_OP_NONE |=> !exec_done && !skip_active
            && accum == $past(accum) && status == $past(status);
    endproperty
    a_ignored_word: assert property (p_ignored_word)
        else $error("foreign word changed state");

    property p_dest_file;
        @(posedge mclk) disable iff (sys_rst)
        (ex_inc || ex_inc_skip) && instr[iol_pkg::DEST_BIT] && peek_addr == faddr
            |=> accum == $past(accum) && peek_data == $past(src_val) + 8'h01;
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("file destination not written or accumulator disturbed");

    property p_accum_dest_keeps_file;
        @(posedge mclk) disable iff (sys_rst)
        (ex_inc || ex_inc_skip) && !instr[iol_pkg::DEST_BIT] && peek_addr == faddr
            |=> peek_data == $past(src_val);
    endproperty
    a_accum_dest_keeps_file: assert property (p_accum_dest_keeps_file)
        else $error("accumulator destination wrote the file register");

    property p_skip_dest_accum;
        @(posedge mclk) disable iff (sys_rst)
        ex_inc_skip && !instr[iol_pkg::DEST_BIT] |=> accum == $past(src_val) + 8'h01;
    endproperty
    a_skip_dest_accum: assert property (p_skip_dest_accum)
        else $error("skip-increment to accumulator gave wrong value");

    property p_skip_status_kept;
        @(posedge mclk) disable iff (sys_rst)
        ex_inc_skip |=> status == $past(status);
    endproperty
    a_skip_status_kept: assert property (p_skip_status_kept)
        else $error("skip-increment changed status");

    property p_skip_discards;
        @(posedge mclk) disable iff (sys_rst)
        ex_inc_skip && src_val == 8'hff |=> skip_active
            ##1 !skip_active && !exec_done && accum == $past(accum)
                && status == $past(status);
    endproperty
    a_skip_discards: assert property (p_skip_discards)
        else $error("zero skip did not discard the following word");

    property p_no_skip_nonzero;
        @(posedge mclk) disable iff (sys_rst)
        ex_inc_skip && src_val != 8'hff |=> !skip_active;
    endproperty
    a_no_skip_nonzero: assert property (p_no_skip_nonzero)
        else $error("skip taken on a non-zero result");

    property p_discarded_quiet;
        @(posedge mclk) disable iff (sys_rst)
        skip_active && $stable(peek_addr) |=> !skip_active && !exec_done
            && accum == $past(accum) && status == $past(status)
            && peek_data == $past(peek_data);
    endproperty
    a_discarded_quiet: assert property (p_discarded_quiet)
        else $error("discarded word changed state");

    property p_idle_no_pulse;
        @(posedge mclk) disable iff (sys_rst)
        !do_exec |=> !exec_done && !skip_active;
    endproperty
    a_idle_no_pulse: assert property (p_idle_no_pulse)
        else $error("pulse without an executed word");

    property p_or_literal;
        @(posedge mclk) disable iff (sys_rst)
        ex_or_lit |=> accum == ($past(accum) | $past(lit)) && exec_done;
    endproperty
    a_or_literal: assert property (p_or_literal)
        else $error("or-literal result wrong");

    property p_zero_only_bit;
        @(posedge mclk) disable iff (sys_rst)
        (ex_inc || ex_or_lit) |=> (status & ~iol_pkg::ZERO_MASK)
            == ($past(status) & ~iol_pkg::ZERO_MASK)
            && status[iol_pkg::ZERO_BIT] == ($past(ex_or_lit)
                ? (($past(accum) | $past(lit)) == 8'h00) : ($past(src_val) == 8'hff));
    endproperty
    a_zero_only_bit: assert property (p_zero_only_bit)
        else $error("zero flag wrong or other status bits moved");

endmodule : iol_exec

//--- hw/iol_pkg.sv
/*
 * iol_pkg: shared constants and types for the increment / or-literal
 * execute block.
 * assumes: 12-bit instruction words, 8-bit datapath, 32 file registers.
 */
package iol_pkg;

    localparam int unsigned INSTR_W   = 12;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned FADDR_W   = 5;
    localparam int unsigned FILE_DEPTH = 32;

    // instruction field positions
    localparam int unsigned DEST_BIT  = 5;
    localparam int unsigned FADDR_LSB = 0;
    localparam int unsigned LIT_LSB   = 0;

    // opcode patterns, compared against the top bits of the word
    localparam logic [5:0] OPC_INCREMENT_FILE_REGISTER = 6'h0a;  // 0010 10
    localparam logic [5:0] OPC_INCREMENT_SKIP_ON_ZERO  = 6'h0f;  // 0011 11
    localparam logic [3:0] OPC_OR_LITERAL_INTO_ACCUM   = 4'hd;   // 1101

    // status byte: zero flag position and reset values
    localparam int unsigned ZERO_BIT  = 2;
    localparam logic [7:0]  ZERO_MASK = 8'h04;
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  ACCUM_RST  = 8'h00;
    localparam logic [7:0]  FILE_RST   = 8'h00;
    localparam logic [7:0]  ONE        = 8'h01;

    typedef enum logic [3:0] {
        IOL_OP_NONE   = 4'h1,
        IOL_OP_INC_FILE = 4'h2,
        IOL_OP_INC_SKIP = 4'h4,
        IOL_OP_OR_LIT   = 4'h8
    } iol_op_t;

endpackage : iol_pkg

//--- hw/iol_alu.sv
/*
 * iol_alu: combinational decode and arithmetic for the three instructions.
 * assumes: operands are stable for the cycle; caller registers results.
 */
`timescale 1ns/1ps
module iol_alu (
    input  wire logic [11:0]      instr,
    input  wire logic [7:0]       accum,
    input  wire logic [7:0]       file_val,
    output iol_pkg::iol_op_t      op,
    output logic      [7:0]       result,
    output logic                  result_zero,
    output logic                  to_file,
    output logic                  upd_zero
);

    function automatic iol_pkg::iol_op_t decode(input logic [11:0] w);
        if (w[11:6] == iol_pkg::OPC_INCREMENT_FILE_REGISTER) begin
            return iol_pkg::IOL_OP_INC_FILE;
        end else if (w[11:6] == iol_pkg::OPC_INCREMENT_SKIP_ON_ZERO) begin
            return iol_pkg::IOL_OP_INC_SKIP;
        end else if (w[11:8] == iol_pkg::OPC_OR_LITERAL_INTO_ACCUM) begin
            return iol_pkg::IOL_OP_OR_LIT;
        end else begin
            return iol_pkg::IOL_OP_NONE;
        end
    endfunction : decode

    always_comb begin
        op          = decode(instr);
        result      = 8'h00;
        to_file     = 1'b0;
        upd_zero    = 1'b0;
        case (op)
            iol_pkg::IOL_OP_INC_FILE: begin
                result   = file_val + iol_pkg::ONE;
                to_file  = instr[iol_pkg::DEST_BIT];
                upd_zero = 1'b1;
            end
            iol_pkg::IOL_OP_INC_SKIP: begin
                result   = file_val + iol_pkg::ONE;
                to_file  = instr[iol_pkg::DEST_BIT];
            end
            iol_pkg::IOL_OP_OR_LIT: begin
                result   = accum | instr[7:0];
                upd_zero = 1'b1;
            end
            default: begin
                result   = 8'h00;
            end
        endcase
        result_zero = (result == 8'h00);
    end

endmodule : iol_alu

//--- tb/iol_prog_mem.sv
/*
 * iol_prog_mem: 16-word program memory that feeds instruction words to the
 * execute block, one per cycle while run is high, from address 0.
 * assumes: bench loads words through wr_* before raising run.
 */
`timescale 1ns/1ps
module iol_prog_mem (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        run,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [11:0] wr_word,
    output logic      [11:0] instr,
    output logic             instr_valid
);
    logic [11:0] mem [16];
    logic [3:0]  pc;

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_word;
        end
        if (sys_rst) begin
            pc          <= 4'h0;
            instr       <= 12'h000;
            instr_valid <= 1'b0;
        end else if (!run) begin
            pc          <= 4'h0;
            instr_valid <= 1'b0;
            // idle bus alternates the last word with its complement, one per cycle
            instr       <= ~instr;
        end else begin
            pc          <= pc + 4'h1;
            instr       <= mem[pc];
            instr_valid <= 1'b1;
        end
    end
endmodule : iol_prog_mem

//--- tb/increment_and_or_literal_exec_bench.sv
/*
 * bench for iol_exec: program memory model feeds words, file registers
 * are observed through the peek port.
 * assumes: design asserts live in the design files.
 */
`timescale 1ns/1ps
module increment_and_or_literal_exec_bench;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        run = 1'b0;
    logic        wr_en = 1'b0;
    logic [3:0]  wr_addr = 4'h0;
    logic [11:0] wr_word = 12'h000;
    logic [4:0]  peek_addr = 5'h00;
    logic [11:0] instr;
    logic        instr_valid;
    logic [7:0]  accum;
    logic [7:0]  status;
    logic [7:0]  peek_data;
    logic        skip_active;
    logic        exec_done;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [7:0]  execs = 8'h00;
    logic [7:0]  skips = 8'h00;

    always #25 mclk = ~mclk;

    iol_prog_mem PMEM (.mclk(mclk), .sys_rst(sys_rst), .run(run), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_word(wr_word), .instr(instr), .instr_valid(instr_valid));
    iol_exec DUT (.mclk(mclk), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
        .peek_addr(peek_addr), .accum(accum), .status(status), .peek_data(peek_data),
        .skip_active(skip_active), .exec_done(exec_done));

    // count pulses, one cycle each
    always @(posedge mclk) begin
        if (exec_done === 1'b1) execs <= execs + 8'h01;
        if (skip_active === 1'b1) skips <= skips + 8'h01;
    end

    task automatic tally_and_finish;
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic put(input logic [3:0] a, input logic [11:0] w);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_word <= w;
        @(posedge mclk);
        wr_en   <= 1'b0;
        // one idle edge so a following put never re-raises wr_en in this step
        @(posedge mclk);
    endtask : put

    task automatic run_prog(input int n);
        execs <= 8'h00;
        skips <= 8'h00;
        run   <= 1'b1;
        repeat (n) @(posedge mclk);
        run <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : run_prog

    task automatic check_file(input logic [4:0] a, input logic [7:0] exp);
        peek_addr <= a;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check(peek_data, exp, "file register");
        @(posedge mclk);
    endtask : check_file

    task automatic t_reset;
        @(negedge mclk);
        check(accum, 8'h00, "accum after reset");
        check(status, 8'h00, "status after reset");
        @(posedge mclk);
        check_file(5'h03, 8'h00);
    endtask : t_reset

    // 255 back-to-back increments of file 3, then one into accum
    task automatic t_increment_file_register;
        for (int i = 0; i < 16; i++) put(4'(i), 12'h2a3);
        run_prog(255);
        check(execs, 8'hff, "one per cycle");
        check(status, 8'h00, "zero clear");
        check_file(5'h03, 8'hff);
        put(4'h0, 12'hd01);
        put(4'h1, 12'h283);
        run_prog(2);
        check(accum, 8'h00, "dest accum");
        check(status, 8'h04, "zero set");
        check_file(5'h03, 8'hff);
    endtask : t_increment_file_register

    // two or-literals back to back
    task automatic t_orlit;
        put(4'h0, 12'hd9a);
        put(4'h1, 12'hd35);
        put(4'h2, 12'hc00);
        run_prog(3);
        check(accum, 8'hbf, "or result");
        check(status, 8'h00, "zero clear");
        check(execs, 8'h02, "one cycle each, foreign word ignored");
    endtask : t_orlit

    // skip on zero discards the next word; a non-zero skip does not
    task automatic t_skip;
        put(4'h0, 12'h3e3);
        put(4'h1, 12'h2a4);
        run_prog(2);
        check(execs, 8'h01, "discarded word");
        check(skips, 8'h01, "one skip");
        check(status, 8'h00, "status kept on zero result");
        check_file(5'h03, 8'h00);
        check_file(5'h04, 8'h00);
        put(4'h0, 12'h2a5);
        put(4'h1, 12'h3c5);
        run_prog(2);
        check(execs, 8'h02, "nothing discarded");
        check(skips, 8'h00, "no skip on non-zero");
        check(accum, 8'h02, "skip inc to accum");
        check_file(5'h05, 8'h01);
    endtask : t_skip

    // reset between programs, with run low, brings back the reset values
    task automatic t_reset_again;
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check(accum, 8'h00, "accum after second reset");
        check_file(5'h05, 8'h00);
    endtask : t_reset_again

    // run takes about 360 cycles
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_increment_file_register();
        t_orlit();
        t_skip();
        t_reset_again();
        tally_and_finish();
    end
endmodule : increment_and_or_literal_exec_bench
